// [verilog/rom_patch.sv]
// ROM patch substitution: compare banks, ROM strobe gating and APB registers
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Each bank replaces one byte pair starting at an even address.
// - On an armed bank hit, ROM strobe is held off, substitute bytes drive bus.
// - Compare registers 0, 1, 2 hold low, middle, upper address bytes.
// - Address bit 0 is ignored, so odd targets match their even pair.
// - Low substitute gives the even byte, high substitute the odd byte.
// - All patch register bits reset to zero; bank registers read back as zero.
module rom_patch
    import rom_patch_pkg::*;
#(
    parameter int BANKS = NUM_BANKS
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // APB slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [APB_AW-1:0]    paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic                      pready_o,
    output logic [31:0]               prdata_o,
    output logic                      pslverr_o,
    // Core read request
    input  wire core_req_t            core_req_i,
    // Masked ROM side
    output rom_req_t                  rom_req_o,
    input  wire logic [2*BYTE_W-1:0]  rom_data_i,
    // Read data back to the core, even byte in the low half
    output logic [2*BYTE_W-1:0]       bus_data_o,
    output logic                      bus_valid_o
);
    typedef struct packed {
        bank_t [BANKS-1:0]   bank;
        logic  [BANKS-1:0]   armed;
        logic  [BANKS-1:0]   last_hit;
        logic                hit_seen;
        rom_req_t            rom;       // Stage 1: request to the ROM
        logic                patched;   // Stage 1: bank answered
        logic [2*BYTE_W-1:0] sub_pair;  // Stage 1: chosen substitute pair
        logic [2*BYTE_W-1:0] data;      // Stage 2: data to the core
        logic                valid;
        logic                pready;
        logic [31:0]         prdata;
        logic                pslverr;
    } state_t;

    state_t s;
    state_t next_s;

    // Decode a register index into a bank number and field
    function automatic field_t decode_field(input logic [IDX_W-1:0] idx, output int bnk);
        logic [IDX_W-1:0] rel;
        field_t           f;
        rel = idx - BANK_BASE;
        f   = FLD_NONE;
        bnk = int'(rel[IDX_W-1:3]);
        if (idx >= BANK_BASE && bnk < BANKS) begin
            case (rel[2:0])
                OFS_CMP_LOW: f = FLD_LOW;
                OFS_CMP_MID: f = FLD_MID;
                OFS_CMP_HI:  f = FLD_HI;
                OFS_SUB_EVN: f = FLD_EVN;
                OFS_SUB_ODD: f = FLD_ODD;
                default:     f = FLD_NONE;
            endcase
        end
        return f;
    endfunction : decode_field

    // Parallel compare of all armed banks, bit 0 ignored
    function automatic logic [BANKS-1:0] bank_hits(input state_t st,
                                                   input logic [ADDR_W-1:0] a);
        logic [BANKS-1:0] h;
        h = '0;
        for (int i = 0; i < BANKS; i++) begin
            h[i] = st.armed[i] && (st.bank[i].cmp == a[ADDR_W-1:1]);
        end
        return h;
    endfunction : bank_hits

    logic [BANKS-1:0] hit_vec;
    logic [IDX_W-1:0] reg_idx;
    logic             apb_setup;
    logic             apb_done;

    assign hit_vec   = bank_hits(s, core_req_i.addr);
    assign reg_idx   = paddr_i[APB_AW-1:2];
    assign apb_setup = psel_i && !penable_i && !s.pready;
    assign apb_done  = psel_i && penable_i && s.pready;

    // Next-state logic: core pipeline and APB slave
    // Hit and miss paths pass the same two register stages, so the core sees equal latency
    // Lowest armed bank wins when several banks claim one pair
    // Sticky hit flag: a hit in the clearing write cycle keeps it set
    always_comb begin
        field_t           f;
        int               bnk;
        logic [2*BYTE_W-1:0] pick;
        next_s = s;
        f      = FLD_NONE;
        bnk    = 0;
        pick   = '0;
        // Lowest numbered hitting bank supplies the pair
        for (int i = BANKS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                pick = {s.bank[i].sub_odd, s.bank[i].sub_evn};
            end
        end
        // Stage 1: gate the ROM strobe on a hit
        next_s.rom.addr  = core_req_i.addr;
        next_s.rom.rd    = core_req_i.rd && (hit_vec == '0);
        next_s.patched   = core_req_i.rd && (hit_vec != '0);
        next_s.sub_pair  = pick;
        if (core_req_i.rd && (hit_vec != '0)) begin
            next_s.last_hit = hit_vec;
            next_s.hit_seen = 1'b1;
        end
        // Stage 2: same latency whether patched or not
        next_s.valid = s.rom.rd || s.patched;
        if (s.patched) begin
            next_s.data = s.sub_pair;
        end else if (s.rom.rd) begin
            next_s.data = rom_data_i;
        end
        // APB: answer in the first access cycle
        next_s.pready = 1'b0;
        if (apb_setup) begin
            f               = decode_field(reg_idx, bnk);
            next_s.pready   = 1'b1;
            next_s.pslverr  = (f == FLD_NONE) && (reg_idx != ENABLE_IDX)
                              && (reg_idx != STATUS_IDX);
            next_s.prdata   = '0;
            if (reg_idx == ENABLE_IDX) begin
                next_s.prdata[BANKS-1:0] = s.armed;
            end else if (reg_idx == STATUS_IDX) begin
                next_s.prdata[BANKS-1:0] = s.last_hit;
                next_s.prdata[31]        = s.hit_seen;
            end
        end
        if (apb_done && pwrite_i) begin
            f = decode_field(reg_idx, bnk);
            case (f)
                FLD_LOW: next_s.bank[bnk].cmp[7:1]   = pwdata_i[7:1];
                FLD_MID: next_s.bank[bnk].cmp[15:8]  = pwdata_i[7:0];
                FLD_HI:  next_s.bank[bnk].cmp[23:16] = pwdata_i[7:0];
                FLD_EVN: next_s.bank[bnk].sub_evn    = pwdata_i[7:0];
                FLD_ODD: next_s.bank[bnk].sub_odd    = pwdata_i[7:0];
                default: begin
                    if (reg_idx == ENABLE_IDX) begin
                        next_s.armed = pwdata_i[BANKS-1:0];
                    end else if (reg_idx == STATUS_IDX) begin
                        next_s.hit_seen = next_s.hit_seen && !pwdata_i[31];
                    end
                end
            endcase
            // A hit in the clearing cycle keeps the flag set
            if (core_req_i.rd && (hit_vec != '0)) begin
                next_s.hit_seen = 1'b1;
            end
        end
    end

    // State register, synchronous reset to zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign pready_o    = s.pready;
    assign prdata_o    = s.prdata;
    assign pslverr_o   = s.pslverr;
    assign rom_req_o   = s.rom;
    assign bus_data_o  = s.data;
    assign bus_valid_o = s.valid;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [2*BYTE_W-1:0] exp_pair;
    assign exp_pair = {s.bank[0].sub_odd, s.bank[0].sub_evn};

    hit_blocks_rom_a: assert property (core_req_i.rd && hit_vec != '0 |=> !rom_req_o.rd)
        else $error("ROM strobe not held off on a bank hit");
    miss_passes_rom_a: assert property (core_req_i.rd && hit_vec == '0
        |=> rom_req_o.rd && rom_req_o.addr == $past(core_req_i.addr))
        else $error("ROM read disturbed without a hit");
    fixed_latency_a: assert property (core_req_i.rd |-> ##2 bus_valid_o)
        else $error("Read data not returned after two cycles");
    bank0_data_a: assert property (core_req_i.rd && hit_vec[0] && !(psel_i && pwrite_i)
        |-> ##2 bus_data_o == $past(exp_pair, 2))
        else $error("Bank 0 substitute pair not on the bus");
    bit0_ignored_a: assert property (s.armed[0]
        && core_req_i.addr[ADDR_W-1:1] == s.bank[0].cmp |-> hit_vec[0])
        else $error("Bank missed the other byte of its pair");
    pair_even_a: assert property (s.armed[0]
        && core_req_i.addr[ADDR_W-1:1] != s.bank[0].cmp |-> !hit_vec[0])
        else $error("Bank hit outside its even-aligned pair");
    cmp_mid_a: assert property (apb_done && pwrite_i
        && reg_idx == BANK_BASE + 14'(OFS_CMP_MID)
        |=> s.bank[0].cmp[15:8] == $past(pwdata_i[7:0]))
        else $error("Middle compare byte not stored in address bits 15:8");
    regs_zero_a: assert property (@(posedge clk_i) disable iff (1'b0)
        !rst_n_i |=> s.bank == '0 && s.armed == '0)
        else $error("Patch registers not zero after reset");
    write_only_a: assert property (apb_setup && reg_idx >= BANK_BASE
        |=> prdata_o == 32'h0000_0000)
        else $error("Patch register read returned data");

    // Register bus answer and refusal
    setup_ready_a: assert property (apb_setup
        |=> pready_o)
        else $error("No answer in the first access cycle");

    ready_pulse_a: assert property (pready_o
        |=> !pready_o)
        else $error("Ready held longer than one cycle");

    unmapped_err_a: assert property (apb_setup && reg_idx < ENABLE_IDX
        |=> pslverr_o && pready_o)
        else $error("Unmapped index not refused");

    mapped_ok_a: assert property (apb_setup && reg_idx == BANK_BASE
        |=> !pslverr_o)
        else $error("Compare register refused");

    err_no_write_a: assert property (apb_done && pwrite_i && pslverr_o
        |=> s.bank == $past(s.bank) && s.armed == $past(s.armed))
        else $error("Refused write changed a bank");

    // Register fields land in the right place
    cmp_low_a: assert property (apb_done && pwrite_i && reg_idx == BANK_BASE
        |=> s.bank[0].cmp[7:1] == $past(pwdata_i[7:1]))
        else $error("Low compare byte not stored in address bits 7:1");

    cmp_hi_a: assert property (apb_done && pwrite_i
        && reg_idx == BANK_BASE + 14'(OFS_CMP_HI) |=> s.bank[0].cmp[23:16] == $past(pwdata_i[7:0]))
        else $error("High compare byte not stored in address bits 23:16");

    sub_evn_a: assert property (apb_done && pwrite_i
        && reg_idx == BANK_BASE + 14'(OFS_SUB_EVN) |=> s.bank[0].sub_evn == $past(pwdata_i[7:0]))
        else $error("Even substitute byte not stored");

    sub_odd_a: assert property (apb_done && pwrite_i
        && reg_idx == BANK_BASE + 14'(OFS_SUB_ODD) |=> s.bank[0].sub_odd == $past(pwdata_i[7:0]))
        else $error("Odd substitute byte not stored");

    armed_write_a: assert property (apb_done && pwrite_i && reg_idx == ENABLE_IDX
        |=> s.armed == $past(pwdata_i[BANKS-1:0]))
        else $error("Arm bits not stored");

    // Core read path
    unarmed_miss_a: assert property (!s.armed[0]
        |-> !hit_vec[0])
        else $error("Unarmed bank reported a hit");

    idle_no_strobe_a: assert property (!core_req_i.rd
        |=> !rom_req_o.rd)
        else $error("ROM strobe without a core read");

    rom_addr_a: assert property (core_req_i.rd
        |=> rom_req_o.addr == $past(core_req_i.addr))
        else $error("ROM address not one cycle behind the request");

    idle_no_valid_a: assert property (!core_req_i.rd
        |-> ##2 !bus_valid_o)
        else $error("Read data valid without a request");

    plain_data_a: assert property (core_req_i.rd && hit_vec == '0
        |-> ##2 bus_data_o == $past(rom_data_i))
        else $error("ROM pair not passed to the core");

    status_hit_a: assert property (core_req_i.rd && hit_vec != '0
        |=> s.hit_seen)
        else $error("Hit flag not set on a bank hit");

    patched_read_c: cover property (core_req_i.rd && hit_vec != '0 ##2 bus_valid_o);
    plain_read_c:   cover property (core_req_i.rd && hit_vec == '0 ##1 rom_req_o.rd);
    two_banks_c:    cover property ($countones(hit_vec) > 1);
    unmapped_c:     cover property (pslverr_o && pready_o);
    hit_clear_c:    cover property (apb_done && pwrite_i && reg_idx == STATUS_IDX && s.hit_seen);
endmodule : rom_patch

`default_nettype wire

// [verilog/rom_patch_pkg.sv]
// Constants and carrier types for the ROM patch substitution block
package rom_patch_pkg;
    localparam int          ADDR_W      = 24;           // Processor address width
    localparam int          BYTE_W      = 8;
    localparam int          NUM_BANKS   = 6;            // Default bank count
    localparam int          APB_AW      = 16;           // APB byte address width
    localparam int          IDX_W       = APB_AW - 2;   // Register index width
    // Register indices; byte address is four times the index
    localparam logic [13:0] BANK_BASE   = 14'h0400;     // First bank's compare register 0
    localparam logic [13:0] BANK_STRIDE = 14'h0008;     // Index step between banks
    localparam logic [2:0]  OFS_CMP_LOW = 3'h0;         // Address bits 7:1
    localparam logic [2:0]  OFS_CMP_MID = 3'h1;         // Address bits 15:8
    localparam logic [2:0]  OFS_CMP_HI  = 3'h2;         // Address bits 23:16
    localparam logic [2:0]  OFS_SUB_EVN = 3'h4;         // Byte for even address
    localparam logic [2:0]  OFS_SUB_ODD = 3'h5;         // Byte for odd address
    localparam logic [13:0] ENABLE_IDX  = 14'h03f0;     // Per-bank arm bits
    localparam logic [13:0] STATUS_IDX  = 14'h03f1;     // Last hit bank and flag
    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam logic [2:0]  DATA_LAT    = 3'h2;         // Cycles from request to data

    // Register field selector from the index decoder
    typedef enum logic [5:0] {
        FLD_NONE = 6'b000001,
        FLD_LOW  = 6'b000010,
        FLD_MID  = 6'b000100,
        FLD_HI   = 6'b001000,
        FLD_EVN  = 6'b010000,
        FLD_ODD  = 6'b100000
    } field_t;

    // One patch bank
    typedef struct packed {
        logic [ADDR_W-1:1] cmp;      // Compare address, bit 0 not stored
        logic [BYTE_W-1:0] sub_evn;
        logic [BYTE_W-1:0] sub_odd;
    } bank_t;

    // Read request from the core
    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
    } core_req_t;

    // Strobe and address towards the masked ROM
    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
    } rom_req_t;
endpackage : rom_patch_pkg

// [testbench/rom_model.sv]
// Masked ROM model answering pair reads in the same cycle
`timescale 1ns/1ps
`default_nettype none
module rom_model
    import rom_patch_pkg::*;
(
    input  wire logic     clk_i,
    input  wire rom_req_t rom_req_i,
    output logic [15:0]   rom_data_o
);
    logic [15:0] idle_pat = 16'h5a3c;

    // Unselected bus shows a pattern that flips every cycle
    always @(posedge clk_i) idle_pat <= ~idle_pat;

    // Pair content from the address, odd byte high
    assign rom_data_o = rom_req_i.rd ? {rom_req_i.addr[7:1], 1'b1, rom_req_i.addr[7:1], 1'b0}
                                     : idle_pat;
endmodule : rom_model
`default_nettype wire

// [testbench/rom_patch_test.sv]
// Self-checking bench for the ROM patch substitution block
`timescale 1ns/1ps
`default_nettype none
module rom_patch_test;
    import rom_patch_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [APB_AW-1:0] paddr_i = '0;
    logic [31:0]       pwdata_i = '0, prdata_o, rdv;
    logic              pready_o, pslverr_o, bus_valid_o, err;
    core_req_t         core_req_i = '0;
    rom_req_t          rom_req_o;
    logic [15:0]       rom_data_i, bus_data_o;
    int                miscompares = 0, check_count = 0;
    localparam logic [7:0] software_interrupt_op = 8'hf9;  // Single-byte trap opcode

    rom_patch u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o), .core_req_i(core_req_i),
        .rom_req_o(rom_req_o), .rom_data_i(rom_data_i), .bus_data_o(bus_data_o),
        .bus_valid_o(bus_valid_o));
    rom_model u_rom (.clk_i(clk_i), .rom_req_i(rom_req_o), .rom_data_o(rom_data_i));

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; read data and error taken at the edge pready is seen
    task apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rdv = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task prog(input int b, input logic [23:0] a, input logic [7:0] ev, od);
        logic [13:0] base;
        base = BANK_BASE + BANK_STRIDE * 14'(b);
        apb(1'b1, base + 14'(OFS_CMP_LOW), {24'h0, a[7:0]});
        apb(1'b1, base + 14'(OFS_CMP_MID), {24'h0, a[15:8]});
        apb(1'b1, base + 14'(OFS_CMP_HI), {24'h0, a[23:16]});
        apb(1'b1, base + 14'(OFS_SUB_EVN), {24'h0, ev});
        apb(1'b1, base + 14'(OFS_SUB_ODD), {24'h0, od});
    endtask : prog

    function automatic logic [15:0] rom_pair(input logic [23:0] a);
        return {a[7:1], 1'b1, a[7:1], 1'b0};
    endfunction : rom_pair

    // Two back-to-back core reads; patched flag predicts the ROM strobe
    task rd_pair(input logic [23:0] a, b, input logic [15:0] ea, eb, input logic pa, pb);
        @(posedge clk_i);
        core_req_i <= {1'b1, a};
        @(posedge clk_i);
        core_req_i <= {1'b1, b};
        #1 chk(rom_req_o.rd, !pa);
        chk(rom_req_o.addr, a);
        @(posedge clk_i);
        core_req_i.rd <= 1'b0;
        #1 chk(rom_req_o.rd, !pb);
        chk(bus_valid_o, 1'b1);
        chk(bus_data_o, ea);
        @(posedge clk_i);
        #1 chk(bus_valid_o, 1'b1);
        chk(bus_data_o, eb);
        @(posedge clk_i);
        #1 chk(bus_valid_o, 1'b0);
    endtask : rd_pair

    task t_regs;
        apb(1'b0, ENABLE_IDX, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, BANK_BASE, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, 14'h0001, 32'h0);
        chk(err, 1'b1);
        rd_pair(24'h000000, 24'hff1230, 16'h0100, rom_pair(24'hff1230), 0, 0);
    endtask : t_regs

    task t_single;
        prog(0, 24'hff1230, 8'haa, 8'h11);
        rd_pair(24'hff1230, 24'hff1231, 16'h3130, 16'h3130, 0, 0);
        apb(1'b1, ENABLE_IDX, 32'h1);
        rd_pair(24'hff1230, 24'hff1231, 16'h11aa, 16'h11aa, 1, 1);
        rd_pair(24'hff1232, 24'hff122e, 16'h3332, 16'h2f2e, 0, 0);
    endtask : t_single

    task t_two_bank;
        prog(0, 24'hff1236, 8'h66, 8'hee);
        prog(1, 24'hff1239, 8'hff, 8'h99);
        apb(1'b0, BANK_BASE + 14'(OFS_SUB_EVN), 32'h0);
        chk(rdv, 32'h0);
        apb(1'b1, ENABLE_IDX, 32'h3);
        rd_pair(24'hff1237, 24'hff1238, 16'hee66, 16'h99ff, 1, 1);
        rd_pair(24'h001238, 24'hff1338, 16'h3938, 16'h3938, 0, 0);
        apb(1'b0, STATUS_IDX, 32'h0);
        chk(rdv[31], 1'b1);
        apb(1'b1, STATUS_IDX, 32'h8000_0000);
        apb(1'b0, STATUS_IDX, 32'h0);
        chk(rdv[31], 1'b0);
    endtask : t_two_bank

    // Trap redirection from an odd start; original even byte kept in the low register
    task t_redirect;
        prog(2, 24'hff5001, 8'h00, software_interrupt_op);
        apb(1'b1, ENABLE_IDX, 32'h7);
        rd_pair(24'hff5000, 24'hff5001, {software_interrupt_op, 8'h00},
                {software_interrupt_op, 8'h00}, 1, 1);
        rd_pair(24'hff5080, 24'hff5081, rom_pair(24'hff5080),
                rom_pair(24'hff5080), 0, 0);
    endtask : t_redirect

    task test_done;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_single();
        t_two_bank();
        t_redirect();
        test_done();
    end

    // Watchdog well beyond the fewer than two hundred cycles the scenarios need
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
endmodule : rom_patch_test
`default_nettype wire
